/* File: dac_pins_pkg.sv */
package dac_pins_pkg;
    // ==========================================================
    // frame format (designer choice)
    localparam int unsigned FRAME_BITS   = 32;
    localparam int unsigned CNT_W        = 6;
    localparam logic [7:0]  CMD_WRITE    = 8'h01;
    localparam logic [7:0]  CMD_READ     = 8'h02;
    localparam logic [7:0]  CMD_CONFIG   = 8'h03;
    localparam logic [7:0]  CMD_SWRESET  = 8'h04;
    localparam logic [7:0]  CMD_NOP      = 8'h00;
    localparam int unsigned CMD_MSB      = 31;
    localparam int unsigned CMD_LSB      = 24;
    localparam int unsigned ADDR_MSB     = 23;
    localparam int unsigned ADDR_LSB     = 22;
    // general_config_one bits
    localparam int unsigned CFG_CLK_EN   = 0;
    localparam int unsigned CFG_MODEM_EN = 1;
    localparam int unsigned CFG_DIV_LSB  = 2;
    localparam int unsigned CFG_DIV_MSB  = 5;
    localparam logic [15:0] CFG_RESET    = 16'h0000;
    localparam logic [15:0] CODE_RESET   = 16'h0000;
    // ==========================================================
    // timing
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned OSC_MHZ        = 10;
    localparam int unsigned WRITE_SCLK_MHZ = 50;
    localparam int unsigned READ_SCLK_MHZ  = 15;
    localparam int unsigned RESET_QUIET_US = 100;
    localparam int unsigned LOAD_PRE_NS    = 500;
    localparam int unsigned LOAD_POST_NS   = 1500;
    // half periods and least times rounded up, oscillator half period rounded down
    localparam int unsigned WR_HALF_CYC =
        (CLK_MHZ + 2 * WRITE_SCLK_MHZ - 1) / (2 * WRITE_SCLK_MHZ);
    localparam int unsigned RD_HALF_CYC =
        (CLK_MHZ + 2 * READ_SCLK_MHZ - 1) / (2 * READ_SCLK_MHZ);
    localparam int unsigned QUIET_CYC    = RESET_QUIET_US * CLK_MHZ;
    localparam int unsigned LOAD_PRE_CYC = (LOAD_PRE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned LOAD_POST_CYC = (LOAD_POST_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned OSC_HALF_CYC = CLK_MHZ / (2 * OSC_MHZ);
    localparam logic [7:0]  ADDR_ID_DEFAULT = 8'h00;
    // AHB-Lite register offsets of the host
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_TXDATA = 8'h04;
    localparam logic [7:0] REG_RXDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_IRQ    = 8'h10;
    localparam logic [7:0] REG_MASK   = 8'h14;
    localparam logic [7:0] REG_LOAD   = 8'h18;
    localparam int unsigned IRQ_DONE  = 0;
    localparam int unsigned IRQ_FAULT = 1;
    localparam int unsigned CTRL_START = 0;
    localparam int unsigned CTRL_RESET = 1;
    localparam int unsigned CTRL_READ  = 2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage

/* File: dac_pins_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface dac_pins_if;
    logic frame_sel_n;
    logic serial_clk;
    logic serial_din;
    logic serial_dout;
    logic reset_n;
    logic output_load_strobe_n;
    logic divided_clock_out;
    logic fault_out;
    logic fault_oe;
    logic fault_n;
    logic address_strap_0;
    logic address_strap_1;
    // open-drain wire with pull-up
    assign fault_n = fault_oe ? fault_out : 1'b1;
    modport device (
        input  frame_sel_n, serial_clk, serial_din, reset_n, output_load_strobe_n,
        input  address_strap_0, address_strap_1,
        output serial_dout, divided_clock_out, fault_out, fault_oe
    );
    modport host (
        output frame_sel_n, serial_clk, serial_din, reset_n, output_load_strobe_n,
        output address_strap_0, address_strap_1,
        input  serial_dout, divided_clock_out, fault_n
    );
endinterface
`default_nettype wire

/* File: dac_pins_device.sv */
`timescale 1ns/1ns
`default_nettype none
module dac_pins_device
    import dac_pins_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    dac_pins_if.device pins,
    input  wire logic       fault_event,
    output logic [15:0]     output_code,
    output logic            modem_coupled,
    output logic [1:0]      address_id,
    output logic [15:0]     config_value
);
    // ==========================================================
    // pin sampling and edge detect
    logic sclk_d_r;
    logic frame_d_r;
    logic [CNT_W-1:0] bit_cnt_r;
    logic [31:0] shift_r;
    logic [31:0] rd_shift_r;
    logic [15:0] pending_r;
    logic [15:0] code_r;
    logic [15:0] cfg_r;
    logic [1:0]  addr_r;
    logic        fault_r;
    logic [3:0]  div_cnt_r;
    logic [3:0]  osc_cnt_r;
    logic        clk_out_r;
    logic        dout_r;
    wire sclk_fall  = sclk_d_r & ~pins.serial_clk;
    wire sclk_rise  = ~sclk_d_r & pins.serial_clk;
    wire frame_rise = ~frame_d_r & pins.frame_sel_n;
    wire in_frame   = ~pins.frame_sel_n;
    wire full_frame = (bit_cnt_r == CNT_W'(FRAME_BITS));
    wire [7:0] cmd  = shift_r[CMD_MSB:CMD_LSB];
    wire hard_rst   = ~hresetn | ~pins.reset_n;
    wire [3:0] div_sel = cfg_r[CFG_DIV_MSB:CFG_DIV_LSB];
    wire osc_tick   = (osc_cnt_r == 4'(OSC_HALF_CYC - 1)); // oscillator half period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_d_r  <= 1'b0;
            frame_d_r <= 1'b1;
        end else begin
            sclk_d_r  <= pins.serial_clk;
            frame_d_r <= pins.frame_sel_n;
        end
    end
    // ==========================================================
    // shift register and frame decode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt_r  <= '0;
            shift_r    <= '0;
            rd_shift_r <= '0;
            pending_r  <= CODE_RESET;
            cfg_r      <= CFG_RESET;
            dout_r     <= 1'b0;
        end else if (!pins.reset_n) begin
            bit_cnt_r  <= '0;
            pending_r  <= CODE_RESET;
            cfg_r      <= CFG_RESET;
            dout_r     <= 1'b0;
        end else if (in_frame && sclk_fall) begin // R3
            shift_r    <= {shift_r[30:0], pins.serial_din}; // R1
            rd_shift_r <= {rd_shift_r[30:0], 1'b0};
            if (!full_frame) bit_cnt_r <= bit_cnt_r + CNT_W'(1);
        end else if (in_frame && sclk_rise) begin // out bit set up before the fall
            dout_r <= rd_shift_r[31]; // R4
        end else if (frame_rise) begin
            bit_cnt_r <= '0;
            if (full_frame && shift_r[ADDR_MSB:ADDR_LSB] == addr_r) begin // R13 R12
                case (cmd)
                    CMD_WRITE:   pending_r  <= shift_r[15:0];
                    CMD_CONFIG:  cfg_r      <= shift_r[15:0];
                    CMD_READ:    rd_shift_r <= {16'h0000, code_r}; // R4
                    CMD_SWRESET: begin
                        pending_r <= CODE_RESET;
                        cfg_r     <= CFG_RESET;
                    end
                    default:     ;
                endcase
            end
        end else if (!in_frame) begin
            bit_cnt_r <= '0;
        end
    end
    // ==========================================================
    // output load, straps, fault, divided clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            code_r <= CODE_RESET;
            addr_r <= 2'b00;
            fault_r <= 1'b0;
        end else begin
            addr_r <= {pins.address_strap_1, pins.address_strap_0}; // R12
            if (!pins.reset_n) begin
                code_r  <= CODE_RESET;
                fault_r <= 1'b0;
            end else begin
                if (!pins.output_load_strobe_n) code_r <= pending_r; // R7
                if (fault_event) fault_r <= 1'b1; // R10
            end
        end
    end
    // oscillator model, then divide its half periods by div_sel + 1
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_cnt_r <= '0;
        end else if (osc_tick) begin
            osc_cnt_r <= '0;
        end else begin
            osc_cnt_r <= osc_cnt_r + 4'h1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_r <= '0;
            clk_out_r <= 1'b0;
        end else if (hard_rst || !cfg_r[CFG_CLK_EN]) begin // R9
            div_cnt_r <= '0;
            clk_out_r <= 1'b0;
        end else if (osc_tick && div_cnt_r == div_sel) begin
            div_cnt_r <= '0;
            clk_out_r <= ~clk_out_r; // R9
        end else if (osc_tick) begin
            div_cnt_r <= div_cnt_r + 4'h1;
        end
    end
    assign pins.serial_dout       = dout_r;
    assign pins.divided_clock_out = clk_out_r;
    assign pins.fault_out         = 1'b0;
    assign pins.fault_oe          = fault_r; // R10
    assign output_code   = code_r;
    assign modem_coupled = cfg_r[CFG_MODEM_EN]; // R11
    assign address_id    = addr_r;
    assign config_value  = cfg_r;
endmodule
`default_nettype wire

/* File: dac_pins_host.sv */
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R1 - device shifts data on falling clock
// R2 - host holds data stable at falling edge
// R3 - frame select low gates all bits
// R4 - readback shifts out, clock at most 15MHz
// R5 - write clock at most 50MHz
// R6 - no frame within 100us of reset
// R7 - load strobe updates output code
// R8 - no load 500ns before, 1.5us after
// R9 - divided clock output off after reset
// R10 - fault pin open-drain, low on fault
// R11 - modem input coupled only when enabled
// R12 - two strap pins give device address
// R13 - write frames act at frame end
module dac_pins_host
    import dac_pins_pkg::*;
#(
    parameter int unsigned QUIET_CYCLES = QUIET_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    dac_pins_if.host pins
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LOW   = 3'b001,
        ST_HIGH  = 3'b010,
        ST_TAIL  = 3'b011,
        ST_QUIET = 3'b100
    } host_state_t;
    host_state_t state_r;
    logic [31:0] tx_r;
    logic [31:0] rx_r;
    logic        read_r;
    logic [CNT_W-1:0] bits_r;
    logic [16:0] cnt_r;
    logic [16:0] post_r;
    logic        sclk_r;
    logic        sync_n_r;
    logic        rst_n_r;
    logic        load_n_r;
    logic        load_req_r;
    logic [1:0]  strap_r;
    logic [1:0]  irq_st_r;
    logic [1:0]  mask_r;
    logic        wr_ph_r;
    logic [7:0]  addr_ph_r;
    // ==========================================================
    // AHB-Lite slave, zero wait states
    wire ahb_wr = hsel & hready & htrans[1] & hwrite;
    wire ahb_rd = hsel & hready & htrans[1] & ~hwrite;
    wire do_wr  = wr_ph_r;
    wire wr_ctrl = do_wr && addr_ph_r == REG_CTRL;
    wire start   = wr_ctrl && hwdata[CTRL_START] && state_r == ST_IDLE;
    wire rst_req = wr_ctrl && hwdata[CTRL_RESET] && state_r == ST_IDLE;
    wire busy    = state_r != ST_IDLE;
    wire [16:0] half = read_r ? 17'(RD_HALF_CYC) : 17'(WR_HALF_CYC);
    // load only between frames: a whole frame outlasts the lead-in window
    wire load_ok   = !busy && post_r == 17'h00000; // R8
    wire last_bit  = bits_r == CNT_W'(FRAME_BITS - 1);
    wire done_evt  = (state_r == ST_TAIL && cnt_r == 17'h00000) ||
                     (state_r == ST_QUIET && cnt_r == 17'h00000);
    wire fault_evt = ~pins.fault_n;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_r   <= 1'b0;
            addr_ph_r <= 8'h00;
        end else begin
            wr_ph_r <= ahb_wr;
            if (ahb_wr || ahb_rd) addr_ph_r <= haddr[7:0];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_r       <= 32'h00000000;
            mask_r     <= 2'b00;
            irq_st_r   <= 2'b00;
            load_req_r <= 1'b0;
            strap_r    <= 2'b00;
            read_r     <= 1'b0;
        end else begin
            // set wins over write-one-to-clear
            irq_st_r <= (irq_st_r & ~((do_wr && addr_ph_r == REG_IRQ) ? hwdata[1:0] : 2'b00))
                        | {fault_evt, done_evt};
            if (do_wr && addr_ph_r == REG_TXDATA) tx_r <= hwdata;
            if (do_wr && addr_ph_r == REG_MASK) mask_r <= hwdata[1:0];
            if (do_wr && addr_ph_r == REG_LOAD) strap_r <= hwdata[2:1];
            if (do_wr && addr_ph_r == REG_LOAD && hwdata[0]) load_req_r <= 1'b1;
            else if (load_req_r && load_ok) load_req_r <= 1'b0;
            if (start) read_r <= hwdata[CTRL_READ];
        end
    end
    // register read mux
    always_comb begin
        case (addr_ph_r)
            REG_TXDATA: hrdata = tx_r;
            REG_RXDATA: hrdata = rx_r;
            REG_STATUS: hrdata = {28'h0000000, load_req_r, ~pins.fault_n, 1'b0, busy};
            REG_IRQ:    hrdata = {30'h00000000, irq_st_r};
            REG_MASK:   hrdata = {30'h00000000, mask_r};
            default:    hrdata = 32'h00000000;
        endcase
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = |(irq_st_r & mask_r);
    // ==========================================================
    // serial frame engine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r  <= ST_IDLE;
            bits_r   <= '0;
            cnt_r    <= 17'h00000;
            sclk_r   <= 1'b0;
            sync_n_r <= 1'b1;
            rst_n_r  <= 1'b1;
            rx_r     <= 32'h00000000;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (rst_req) begin
                        rst_n_r <= 1'b0;
                        cnt_r   <= 17'(QUIET_CYCLES);
                        state_r <= ST_QUIET; // R6
                    end else if (start) begin
                        sync_n_r <= 1'b0; // R3
                        sclk_r   <= 1'b1;
                        bits_r   <= '0;
                        cnt_r    <= hwdata[CTRL_READ] ? 17'(RD_HALF_CYC) : 17'(WR_HALF_CYC);
                        state_r  <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (cnt_r == 17'h00001) begin
                        sclk_r  <= 1'b0; // R5 R4
                        cnt_r   <= half;
                        rx_r    <= {rx_r[30:0], pins.serial_dout};
                        state_r <= ST_LOW;
                    end else cnt_r <= cnt_r - 17'h00001;
                end
                ST_LOW: begin
                    if (cnt_r == 17'h00001) begin
                        if (bits_r == CNT_W'(FRAME_BITS - 1)) begin
                            sync_n_r <= 1'b1; // R13
                            cnt_r    <= 17'(LOAD_POST_CYC);
                            state_r  <= ST_TAIL;
                        end else begin
                            sclk_r  <= 1'b1;
                            cnt_r   <= half;
                            bits_r  <= bits_r + CNT_W'(1);
                            state_r <= ST_HIGH;
                        end
                    end else cnt_r <= cnt_r - 17'h00001;
                end
                ST_TAIL: begin
                    if (cnt_r == 17'h00000) state_r <= ST_IDLE;
                    else cnt_r <= cnt_r - 17'h00001;
                end
                ST_QUIET: begin
                    rst_n_r <= 1'b1;
                    if (cnt_r == 17'h00000) state_r <= ST_IDLE; // R6
                    else cnt_r <= cnt_r - 17'h00001;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
    // data changes on rising edge, stable at the falling edge
    logic sdi_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sdi_r <= 1'b0;
        end else if (start) begin
            sdi_r <= tx_r[31]; // R2
        end else if (state_r == ST_LOW && cnt_r == 17'h00001 && !last_bit) begin
            sdi_r <= tx_r[5'(FRAME_BITS - 2) - 5'(bits_r)]; // R2
        end
    end
    // load strobe one cycle, outside keep-out window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_n_r <= 1'b1;
            post_r   <= 17'h00000;
        end else begin
            load_n_r <= ~(load_req_r && load_ok && load_n_r); // R8 R7
            post_r   <= (state_r == ST_TAIL) ? cnt_r : 17'h00000;
        end
    end
    assign pins.frame_sel_n          = sync_n_r;
    assign pins.serial_clk           = sclk_r;
    assign pins.serial_din           = sdi_r;
    assign pins.reset_n              = rst_n_r;
    assign pins.output_load_strobe_n = load_n_r;
    assign pins.address_strap_0      = strap_r[0];
    assign pins.address_strap_1      = strap_r[1];
endmodule
`default_nettype wire

/* File: dac_pins_props.sv */
`timescale 1ns/1ns
`default_nettype none
module dac_pins_props
    import dac_pins_pkg::*;
#(
    parameter int unsigned QUIET_CYCLES = QUIET_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic frame_sel_n,
    input wire logic serial_clk,
    input wire logic serial_din,
    input wire logic reset_n,
    input wire logic output_load_strobe_n,
    input wire logic divided_clock_out,
    input wire logic fault_out,
    input wire logic fault_oe
);
    // ==========
    // helper counters
    logic [31:0] quiet_r;
    logic [31:0] load_age_r;
    logic [31:0] end_age_r;
    logic [7:0]  falls_r;
    logic        rst_q_r;
    logic        sclk_q_r;
    logic        sel_q_r;

    // cycles since reset pin fell, load strobe, frame end; falls per frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet_r    <= QUIET_CYCLES;
            load_age_r <= 32'hFFFF;
            end_age_r  <= 32'hFFFF;
            falls_r    <= 8'h00;
            rst_q_r    <= 1'b1;
            sclk_q_r   <= 1'b0;
            sel_q_r    <= 1'b1;
        end else begin
            rst_q_r    <= reset_n;
            sclk_q_r   <= serial_clk;
            sel_q_r    <= frame_sel_n;
            quiet_r    <= (rst_q_r && !reset_n) ? 32'h0
                        : quiet_r + {31'h0, quiet_r < QUIET_CYCLES};
            load_age_r <= !output_load_strobe_n ? 32'h0
                        : load_age_r + {31'h0, load_age_r < 32'hFFFF};
            end_age_r  <= (frame_sel_n && !sel_q_r) ? 32'h0
                        : end_age_r + {31'h0, end_age_r < 32'hFFFF};
            falls_r    <= frame_sel_n ? 8'h00 : falls_r + {7'h0, sclk_q_r && !serial_clk};
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==========
    // pin checks
    a_sclk_idle: assert property (frame_sel_n && sel_q_r |-> $stable(serial_clk))
        else $error("serial clock moved outside a frame");
    a_din_stable: assert property (!frame_sel_n && $fell(serial_clk) |-> $stable(serial_din))
        else $error("data changed at the sampling edge");
    a_sclk_high: assert property ($rose(serial_clk) |=> serial_clk)
        else $error("serial clock high phase too short");
    a_frame_bits: assert property ($rose(frame_sel_n) |-> falls_r == 8'(FRAME_BITS))
        else $error("frame ended with wrong bit count");
    a_reset_quiet: assert property ($fell(frame_sel_n) |-> reset_n && quiet_r >= QUIET_CYCLES - 1)
        else $error("frame started inside reset quiet time");
    a_load_pre: assert property ($rose(frame_sel_n) |->
        output_load_strobe_n && load_age_r >= LOAD_PRE_CYC - 1)
        else $error("load strobe too close before frame end");
    a_load_post: assert property (!output_load_strobe_n |-> end_age_r >= LOAD_POST_CYC - 1)
        else $error("load strobe too soon after frame end");
    a_load_pulse: assert property ($fell(output_load_strobe_n) |=> output_load_strobe_n)
        else $error("load strobe longer than one cycle");
    a_fault_drive: assert property (fault_oe |-> !fault_out)
        else $error("fault pin driven high");
    a_fault_clear: assert property (!reset_n |=> ##[0:2] !fault_oe)
        else $error("fault kept through reset pin");
    a_divided_clock_out_off: assert property (!reset_n |=> ##[0:2] !divided_clock_out)
        else $error("clock output running after reset pin");
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb
    import dac_pins_pkg::*;
;
    localparam int unsigned QUIET = 50;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fault_event = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b000;
    logic        hreadyout, hresp, irq, modem_coupled;
    logic [15:0] output_code, config_value;
    logic [1:0]  address_id;
    int          fail_count = 0, check_count = 0;

    // free-running bus clock
    always #4 hclk = ~hclk;

    dac_pins_if pins();
    dac_pins_host #(.QUIET_CYCLES(QUIET)) dac_pins_host_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .pins(pins)
    );
    dac_pins_device dac_pins_device_inst (
        .hclk(hclk), .hresetn(hresetn), .pins(pins), .fault_event(fault_event),
        .output_code(output_code), .modem_coupled(modem_coupled),
        .address_id(address_id), .config_value(config_value)
    );
    dac_pins_props #(.QUIET_CYCLES(QUIET)) dac_pins_props_inst (
        .hclk(hclk), .hresetn(hresetn), .frame_sel_n(pins.frame_sel_n),
        .serial_clk(pins.serial_clk), .serial_din(pins.serial_din), .reset_n(pins.reset_n),
        .output_load_strobe_n(pins.output_load_strobe_n),
        .divided_clock_out(pins.divided_clock_out), .fault_out(pins.fault_out),
        .fault_oe(pins.fault_oe)
    );

    // ==========
    // bus and check tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        xfer(a, 1'b1, d, v);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        xfer(a, 1'b0, 32'h0, v);
        check(what, v, exp);
    endtask

    task automatic wait_clear(input logic [31:0] m);
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            xfer(REG_STATUS, 1'b0, 32'h0, s);
            n++;
        end while ((s & m) !== 32'h0 && n < 500);
        check("status_wait", s & m, 32'h0);
    endtask

    task automatic send(input logic [7:0] cmd, input logic [1:0] adr, input logic [15:0] d);
        wr(REG_TXDATA, {cmd, adr, 6'h00, d});
        wr(REG_CTRL, 32'h1);
        wait_clear(32'h1);
    endtask

    task automatic load_code(input logic [15:0] exp);
        wr(REG_LOAD, 32'h7);
        wait_clear(32'h8);
        repeat (4) @(posedge hclk);
        #1 check("code", {16'h0, output_code}, {16'h0, exp});
    endtask

    task automatic hold_len(input logic lvl, output int n);
        for (n = 0; n < 300 && pins.serial_clk === lvl; n++) begin
            @(posedge hclk);
            #1;
        end
    endtask

    // ==========
    // scenarios
    task automatic t_reset_state();
        rd_chk(REG_STATUS, 32'h0, "status_rst");
        rd_chk(REG_MASK, 32'h0, "mask_rst");
        rd_chk(8'h1C, 32'h0, "unmapped");
        check("divided_clock_out_rst", {31'h0, pins.divided_clock_out}, 32'h0);
        check("modem_rst", {31'h0, modem_coupled}, 32'h0);
    endtask

    task automatic t_write_load();
        send(CMD_WRITE, 2'b00, 16'hA5C3);
        check("code_held", {16'h0, output_code}, 32'h0);
        rd_chk(REG_IRQ, 32'h1, "irq_done");
        check("irq_masked", {31'h0, irq}, 32'h0);
        wr(REG_MASK, 32'h1);
        #1 check("irq_on", {31'h0, irq}, 32'h1);
        wr(REG_IRQ, 32'h1);
        #1 check("irq_off", {31'h0, irq}, 32'h0);
        load_code(16'hA5C3);
    endtask

    task automatic t_straps();
        wr(REG_LOAD, 32'h6);
        repeat (3) @(posedge hclk);
        #1 check("strap_id", {30'h0, address_id}, 32'h3);
        send(CMD_WRITE, 2'b00, 16'h1234);
        load_code(16'hA5C3);
        send(CMD_WRITE, 2'b11, 16'h5A5A);
        load_code(16'h5A5A);
    endtask

    task automatic t_config();
        int   n;
        logic prev;
        send(CMD_CONFIG, 2'b11, 16'h0003);
        #1 check("config", {16'h0, config_value}, 32'h3);
        check("modem_on", {31'h0, modem_coupled}, 32'h1);
        n = 0;
        repeat (8 * OSC_HALF_CYC) begin
            prev = pins.divided_clock_out;
            @(posedge hclk);
            #1 n += int'(pins.divided_clock_out !== prev);
        end
        check("divided_clock_out_toggles", 32'(n), 32'h8);
    endtask

    task automatic t_readback();
        int n;
        wr(REG_TXDATA, {CMD_READ, 2'b11, 22'h0});
        wr(REG_CTRL, 32'h5);
        wait_clear(32'h1);
        wr(REG_TXDATA, {CMD_NOP, 2'b11, 22'h0});
        wr(REG_CTRL, 32'h5);
        #1 hold_len(1'b0, n);
        hold_len(1'b1, n);
        hold_len(1'b0, n);
        check("read_half", {31'h0, n >= RD_HALF_CYC}, 32'h1);
        wait_clear(32'h1);
        rd_chk(REG_RXDATA, 32'h00005A5A, "readback");
    endtask

    task automatic t_fault();
        wr(REG_MASK, 32'h0);
        wr(REG_IRQ, 32'h3);
        fault_event <= 1'b1;
        @(posedge hclk);
        fault_event <= 1'b0;
        repeat (3) @(posedge hclk);
        #1 check("fault_pin", {31'h0, pins.fault_n}, 32'h0);
        rd_chk(REG_STATUS, 32'h4, "status_fault");
        rd_chk(REG_IRQ, 32'h2, "irq_fault");
        check("irq_masked", {31'h0, irq}, 32'h0);
        wr(REG_MASK, 32'h2);
        #1 check("irq_fault_on", {31'h0, irq}, 32'h1);
        wr(REG_CTRL, 32'h2);
        wait_clear(32'h1);
        #1 check("fault_gone", {31'h0, pins.fault_n}, 32'h1);
        check("code_rst", {16'h0, output_code}, 32'h0);
        check("divided_clock_out_off", {31'h0, pins.divided_clock_out}, 32'h0);
        check("modem_off", {31'h0, modem_coupled}, 32'h0);
        wr(REG_IRQ, 32'h3);
        rd_chk(REG_IRQ, 32'h0, "irq_clear");
        #1 check("irq_low", {31'h0, irq}, 32'h0);
        send(CMD_WRITE, 2'b11, 16'hFFFF);
        load_code(16'hFFFF);
    endtask

    // reset, then the scenarios in turn
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_state();
        t_write_load();
        t_straps();
        t_config();
        t_readback();
        t_fault();
        wrap_up();
    end

    // watchdog against a hang
    initial begin
        repeat (40000) @(posedge hclk);
        fail_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
